/* logic/mft_defines.vh */
`ifndef MFT_DEFINES_VH
`define MFT_DEFINES_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define MFT_AW 6
`define MFT_DW 16
`define MFT_NSUB 4
`define MFT_PW 8

// ----------------------------------------
// Register byte addresses (even, one word each)
// ----------------------------------------
`define MFT_A_CTRL 6'h00
`define MFT_A_PRS12 6'h02
`define MFT_A_PRS34 6'h04
`define MFT_A_CNT_BASE 6'h08
`define MFT_A_PER_BASE 6'h10
`define MFT_A_DTY_BASE 6'h18
`define MFT_A_END 6'h20
`define MFT_ADDR_STEP 2
`define MFT_SUB_MSB 2
`define MFT_SUB_LSB 1
`define MFT_ODD_BIT 0

// ----------------------------------------
// Run-control bits per subsystem
// ----------------------------------------
`define MFT_RUN_W 2

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define MFT_CTRL_RUN_LSB 0
`define MFT_CTRL_MODE_LSB 8
`define MFT_CTRL_MASK 16'h0FFF

// ----------------------------------------
// Reset values and count increments
// ----------------------------------------
`define MFT_ZERO16 16'h0000
`define MFT_ZERO8 8'h00
`define MFT_ONE16 16'h0001
`define MFT_ONE8 8'h01

`endif

/* logic/mft_presc.v */
`timescale 1ns/1ps
`default_nettype none
`include "mft_defines.vh"

module mft_presc (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Control
    input wire run,
    input wire [`MFT_PW-1:0] cmp,
    // Counting strobe
    output wire tick
);

// ----------------------------------------
// Prescaler counter
// ----------------------------------------
reg [`MFT_PW-1:0] pcnt_r;
reg [`MFT_PW-1:0] pcnt_nxt;

assign tick = run && (pcnt_r == cmp);

always @* begin
    if (!run || tick) begin
        pcnt_nxt = `MFT_ZERO8;
    end else begin
        pcnt_nxt = pcnt_r + `MFT_ONE8;
    end
end

always @(posedge clk) begin
    if (reset) begin
        pcnt_r <= `MFT_ZERO8;
    end else begin
        pcnt_r <= pcnt_nxt;
    end
end

endmodule // mft_presc
`default_nettype wire

/* logic/mft_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "mft_defines.vh"

module mft_timer (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Register port, word wide
    input wire [`MFT_AW-1:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [`MFT_DW-1:0] bus_wdata,
    output wire [`MFT_DW-1:0] bus_rdata,
    output wire bus_rvalid,
    // Capture event pins, one pair per subsystem
    input wire [`MFT_NSUB-1:0] cap_a_in,
    input wire [`MFT_NSUB-1:0] cap_b_in,
    // PWM outputs
    output wire [`MFT_NSUB-1:0] pwm_out
);

// ----------------------------------------
// Global control registers
// ----------------------------------------
reg [`MFT_DW-1:0] ctrl_r;
reg [`MFT_DW-1:0] ctrl_nxt;
reg [`MFT_DW-1:0] prs12_r;
reg [`MFT_DW-1:0] prs12_nxt;
reg [`MFT_DW-1:0] prs34_r;
reg [`MFT_DW-1:0] prs34_nxt;
wire [2*`MFT_DW-1:0] prs_all;

assign prs_all = {prs34_r, prs12_r};

// Address decode for the shared control words
always @* begin
    ctrl_nxt = ctrl_r;
    prs12_nxt = prs12_r;
    prs34_nxt = prs34_r;
    if (bus_wr) begin
        if (bus_addr == `MFT_A_CTRL) begin
            ctrl_nxt = bus_wdata & `MFT_CTRL_MASK;
        end else if (bus_addr == `MFT_A_PRS12) begin
            prs12_nxt = bus_wdata;
        end else if (bus_addr == `MFT_A_PRS34) begin
            prs34_nxt = bus_wdata;
        end
    end
end

always @(posedge clk) begin
    if (reset) begin
        ctrl_r <= `MFT_ZERO16;
        prs12_r <= `MFT_ZERO16;
        prs34_r <= `MFT_ZERO16;
    end else begin
        ctrl_r <= ctrl_nxt;
        prs12_r <= prs12_nxt;
        prs34_r <= prs34_nxt;
    end
end

// ----------------------------------------
// Capture pin synchronisers and edge detect
// ----------------------------------------
reg [`MFT_NSUB-1:0] cap_a_meta_r;
reg [`MFT_NSUB-1:0] cap_a_sync_r;
reg [`MFT_NSUB-1:0] cap_a_prev_r;
reg [`MFT_NSUB-1:0] cap_b_meta_r;
reg [`MFT_NSUB-1:0] cap_b_sync_r;
reg [`MFT_NSUB-1:0] cap_b_prev_r;
wire [`MFT_NSUB-1:0] cap_a_evt;
wire [`MFT_NSUB-1:0] cap_b_evt;

always @(posedge clk) begin
    if (reset) begin
        cap_a_meta_r <= {`MFT_NSUB{1'b0}};
        cap_a_sync_r <= {`MFT_NSUB{1'b0}};
        cap_a_prev_r <= {`MFT_NSUB{1'b0}};
        cap_b_meta_r <= {`MFT_NSUB{1'b0}};
        cap_b_sync_r <= {`MFT_NSUB{1'b0}};
        cap_b_prev_r <= {`MFT_NSUB{1'b0}};
    end else begin
        cap_a_meta_r <= cap_a_in;
        cap_a_sync_r <= cap_a_meta_r;
        cap_a_prev_r <= cap_a_sync_r;
        cap_b_meta_r <= cap_b_in;
        cap_b_sync_r <= cap_b_meta_r;
        cap_b_prev_r <= cap_b_sync_r;
    end
end

// Rising edges only
assign cap_a_evt = cap_a_sync_r & ~cap_a_prev_r;
assign cap_b_evt = cap_b_sync_r & ~cap_b_prev_r;

// ----------------------------------------
// Timer subsystems
// ----------------------------------------
wire [`MFT_NSUB*`MFT_DW-1:0] cnt_flat;
wire [`MFT_NSUB*`MFT_DW-1:0] per_flat;
wire [`MFT_NSUB*`MFT_DW-1:0] dty_flat;

genvar i;
generate
    for (i = 0; i < `MFT_NSUB; i = i + 1) begin : g_sub
        localparam integer A_CNT = `MFT_A_CNT_BASE + `MFT_ADDR_STEP * i;
        localparam integer A_PER = `MFT_A_PER_BASE + `MFT_ADDR_STEP * i;
        localparam integer A_DTY = `MFT_A_DTY_BASE + `MFT_ADDR_STEP * i;

        reg [`MFT_DW-1:0] cnt_r;
        reg [`MFT_DW-1:0] cnt_nxt;
        reg [`MFT_DW-1:0] per_r;
        reg [`MFT_DW-1:0] per_nxt;
        reg [`MFT_DW-1:0] dty_r;
        reg [`MFT_DW-1:0] dty_nxt;
        reg [`MFT_DW-1:0] per_act_r;
        reg [`MFT_DW-1:0] per_act_nxt;
        reg [`MFT_DW-1:0] dty_act_r;
        reg [`MFT_DW-1:0] dty_act_nxt;
        reg pwm_r;
        reg pwm_nxt;
        wire run_w;
        wire pwm_mode_w;
        wire tick_w;
        wire wr_cnt_w;
        wire wr_per_w;
        wire wr_dty_w;
        wire cap_a_hit_w;
        wire cap_b_hit_w;
        wire wrap_w;
        wire load_act_w;

        // ------------------------------------
        // Decode and qualifiers
        // ------------------------------------
        // Either run-control bit starts the counter
        assign run_w = |ctrl_r[`MFT_CTRL_RUN_LSB + `MFT_RUN_W * i +: `MFT_RUN_W];
        assign pwm_mode_w = ctrl_r[`MFT_CTRL_MODE_LSB + i];
        assign wr_cnt_w = bus_wr && (bus_addr == A_CNT[`MFT_AW-1:0]);
        assign wr_per_w = bus_wr && (bus_addr == A_PER[`MFT_AW-1:0]);
        assign wr_dty_w = bus_wr && (bus_addr == A_DTY[`MFT_AW-1:0]);
        // Capture events only count outside PWM mode
        assign cap_a_hit_w = !pwm_mode_w && cap_a_evt[i];
        assign cap_b_hit_w = !pwm_mode_w && cap_b_evt[i];

        mft_presc u_presc (
            .clk(clk),
            .reset(reset),
            .run(run_w),
            .cmp(prs_all[`MFT_PW * i +: `MFT_PW]),
            .tick(tick_w)
        );

        // Period boundary: count meets the active period in PWM mode
        assign wrap_w = tick_w && pwm_mode_w && (cnt_r == per_act_r);
        // Halted counters track the written values, so a restart begins clean
        assign load_act_w = !run_w || wrap_w;

        // ------------------------------------
        // Counter
        // ------------------------------------
        always @* begin
            cnt_nxt = cnt_r;
            if (!run_w) begin
                // Writes only land while halted
                if (wr_cnt_w) begin
                    cnt_nxt = bus_wdata;
                end
            end else if (wrap_w) begin
                cnt_nxt = `MFT_ZERO16;
            end else if (tick_w) begin
                cnt_nxt = cnt_r + `MFT_ONE16;
            end
        end

        always @(posedge clk) begin
            if (reset) begin
                cnt_r <= `MFT_ZERO16;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end

        // ------------------------------------
        // Period/capture and duty/capture
        // ------------------------------------
        always @* begin
            per_nxt = per_r;
            dty_nxt = dty_r;
            // Capture beats a software write in the same cycle
            if (cap_a_hit_w) begin
                per_nxt = cnt_r;
            end else if (wr_per_w) begin
                per_nxt = bus_wdata;
            end
            if (cap_b_hit_w) begin
                dty_nxt = cnt_r;
            end else if (wr_dty_w) begin
                dty_nxt = bus_wdata;
            end
        end

        always @(posedge clk) begin
            if (reset) begin
                per_r <= `MFT_ZERO16;
                dty_r <= `MFT_ZERO16;
            end else begin
                per_r <= per_nxt;
                dty_r <= dty_nxt;
            end
        end

        // ------------------------------------
        // Active compare values
        // ------------------------------------
        always @* begin
            per_act_nxt = per_act_r;
            dty_act_nxt = dty_act_r;
            if (load_act_w) begin
                per_act_nxt = per_r;
                dty_act_nxt = dty_r;
            end
        end

        always @(posedge clk) begin
            if (reset) begin
                per_act_r <= `MFT_ZERO16;
                dty_act_r <= `MFT_ZERO16;
            end else begin
                per_act_r <= per_act_nxt;
                dty_act_r <= dty_act_nxt;
            end
        end

        // ------------------------------------
        // PWM output
        // ------------------------------------
        always @* begin
            pwm_nxt = 1'b0;
            if (pwm_mode_w && run_w && (cnt_r < dty_act_r)) begin
                pwm_nxt = 1'b1;
            end
        end

        always @(posedge clk) begin
            if (reset) begin
                pwm_r <= 1'b0;
            end else begin
                pwm_r <= pwm_nxt;
            end
        end

        assign pwm_out[i] = pwm_r;
        assign cnt_flat[`MFT_DW * i +: `MFT_DW] = cnt_r;
        assign per_flat[`MFT_DW * i +: `MFT_DW] = per_r;
        assign dty_flat[`MFT_DW * i +: `MFT_DW] = dty_r;
    end
endgenerate

// ----------------------------------------
// Read path
// ----------------------------------------
reg [`MFT_DW-1:0] rdata_r;
reg [`MFT_DW-1:0] rdata_nxt;
reg rvalid_r;
wire [1:0] sub_idx;

assign sub_idx = bus_addr[`MFT_SUB_MSB:`MFT_SUB_LSB];

// Odd addresses hold no word register and read as zero
always @* begin
    rdata_nxt = `MFT_ZERO16;
    if (bus_addr[`MFT_ODD_BIT]) begin
        rdata_nxt = `MFT_ZERO16;
    end else if (bus_addr == `MFT_A_CTRL) begin
        rdata_nxt = ctrl_r;
    end else if (bus_addr == `MFT_A_PRS12) begin
        rdata_nxt = prs12_r;
    end else if (bus_addr == `MFT_A_PRS34) begin
        rdata_nxt = prs34_r;
    end else if (bus_addr >= `MFT_A_CNT_BASE && bus_addr < `MFT_A_PER_BASE) begin
        rdata_nxt = cnt_flat[`MFT_DW * sub_idx +: `MFT_DW];
    end else if (bus_addr >= `MFT_A_PER_BASE && bus_addr < `MFT_A_DTY_BASE) begin
        rdata_nxt = per_flat[`MFT_DW * sub_idx +: `MFT_DW];
    end else if (bus_addr >= `MFT_A_DTY_BASE && bus_addr < `MFT_A_END) begin
        rdata_nxt = dty_flat[`MFT_DW * sub_idx +: `MFT_DW];
    end
end

always @(posedge clk) begin
    if (reset) begin
        rdata_r <= `MFT_ZERO16;
        rvalid_r <= 1'b0;
    end else begin
        rvalid_r <= bus_rd;
        if (bus_rd) begin
            rdata_r <= rdata_nxt;
        end
    end
end

assign bus_rdata = rdata_r;
assign bus_rvalid = rvalid_r;

endmodule // mft_timer
`default_nettype wire

/* testbench/mft_timer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mft_timer_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [5:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid,
    // Pins
    input wire logic [3:0] cap_a_in,
    input wire logic [3:0] cap_b_in,
    input wire logic [3:0] pwm_out
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
logic [15:0] ctrl_r;
logic [3:0] on_w;
// Shadow of the control word, for gating checks
always @(posedge clk) begin
    if (reset) ctrl_r <= 16'h0000;
    else if (bus_wr && bus_addr == 6'h00) ctrl_r <= bus_wdata;
end
always_comb begin
    for (int i = 0; i < 4; i++) on_w[i] = (|ctrl_r[2*i +: 2]) & ctrl_r[8+i];
end
a_rvalid_follows_rd: assert property (bus_rd |=> bus_rvalid) else $error("no read answer");
a_rvalid_needs_rd: assert property (!bus_rd |=> !bus_rvalid) else $error("stray read answer");
a_rdata_holds: assert property (!bus_rvalid |-> $stable(bus_rdata)) else $error("read data moved");
a_reset_quiet: assert property ($fell(reset) |-> pwm_out == 4'h0 && !bus_rvalid) else $error("outputs live");
a_pwm_gated: assert property ((pwm_out & ~(on_w | $past(on_w))) == 4'h0) else $error("pwm while off");
a_unmapped_zero: assert property (bus_rd && bus_addr >= 6'h20 |=> bus_rdata == 16'h0000) else $error("unmapped");
a_odd_zero: assert property (bus_rd && bus_addr[0] |=> bus_rdata == 16'h0000) else $error("odd address");
a_ctrl_readback: assert property (bus_rd && bus_addr == 6'h00 |=> bus_rdata == ($past(ctrl_r) & 16'h0FFF))
    else $error("control readback");
endmodule // mft_timer_chk
bind mft_timer mft_timer_chk u_chk (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .cap_a_in(cap_a_in), .cap_b_in(cap_b_in), .pwm_out(pwm_out));
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
logic clk = 0, reset = 1, bus_wr = 0, bus_rd = 0, bus_rvalid;
logic [5:0] bus_addr = 6'h00;
logic [15:0] bus_wdata = 16'h0000, bus_rdata, d0, d1;
logic [3:0] cap_a_in = 4'h0, cap_b_in = 4'h0, pwm_out;
int fails = 0, num_checks = 0;
mft_timer DUT (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .cap_a_in(cap_a_in),
    .cap_b_in(cap_b_in), .pwm_out(pwm_out));
initial begin
    forever #4 clk = ~clk;
end
// ----------------------------------------
// Bus tasks and checks
// ----------------------------------------
task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
        fails++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= v;
    @(posedge clk);
    bus_wr <= 1'b0;
endtask
task rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk);
    bus_rd <= 1'b1; bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk({15'h0000, bus_rvalid}, 16'h0001);
    v = bus_rdata;
endtask
task rdc(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(v, e);
endtask
task pwm_high(input int e);
    int n;
    n = 0;
    repeat (100) begin
        @(posedge clk);
        #1;
        n += pwm_out[0];
    end
    chk(16'(n), 16'(e));
endtask
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
end
initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++) rdc(6'h08 + 6'(2 * i), 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 12; i++) wr(6'h08 + 6'(2 * i), 16'hA5C0 + 16'(i));
    for (int i = 0; i < 12; i++) rdc(6'h08 + 6'(2 * i), 16'hA5C0 + 16'(i));
    rdc(6'h3E, 16'h0000);
    rdc(6'h11, 16'h0000);
    wr(6'h00, 16'hF000);
    rdc(6'h00, 16'h0000);
    $display("readback done");
    wr(6'h02, 16'h0003);
    wr(6'h08, 16'h0000);
    wr(6'h00, 16'h0001);
    rd(6'h08, d0);
    repeat (6) @(posedge clk);
    rd(6'h08, d1);
    chk(d1 - d0, 16'h0002);
    wr(6'h00, 16'h0000);
    wr(6'h08, 16'h1234);
    rdc(6'h08, 16'h1234);
    $display("counting done");
    wr(6'h02, 16'h0000);
    wr(6'h08, 16'h0000);
    wr(6'h10, 16'h0009);
    wr(6'h18, 16'h0004);
    wr(6'h00, 16'h0101);
    repeat (20) @(posedge clk);
    pwm_high(40);
    wr(6'h18, 16'h0007);
    rdc(6'h18, 16'h0007);
    repeat (30) @(posedge clk);
    pwm_high(70);
    wr(6'h10, 16'h0013);
    rdc(6'h10, 16'h0013);
    repeat (40) @(posedge clk);
    pwm_high(35);
    @(posedge clk);
    cap_a_in <= 4'h1;
    repeat (4) @(posedge clk);
    cap_a_in <= 4'h0;
    repeat (6) @(posedge clk);
    rdc(6'h10, 16'h0013);
    $display("pwm done");
    wr(6'h0A, 16'h0055);
    cap_a_in <= 4'h2;
    cap_b_in <= 4'h2;
    repeat (4) @(posedge clk);
    cap_a_in <= 4'h0;
    cap_b_in <= 4'h0;
    repeat (6) @(posedge clk);
    rdc(6'h12, 16'h0055);
    rdc(6'h1A, 16'h0055);
    $display("capture done");
    wr(6'h04, 16'h0300);
    wr(6'h0E, 16'h0000);
    wr(6'h00, 16'h0080);
    rd(6'h0E, d0);
    repeat (6) @(posedge clk);
    rd(6'h0E, d1);
    chk(d1 - d0, 16'h0002);
    $display("prescale done");
    test_done();
end
endmodule // tb
`default_nettype wire
